// *** src/lmic_regs.vh ***
// Register map, field positions, reset values and timing counts of the classifier
// Functional notes
// - Green health LED toggles once per scan
// - Module fault: red on, green forced off
// - Power LED needs field voltage and regulator
// - Contact LED on when closed or shorted
// - Line LED on when open or shorted
// - Per-point suppress hides line LED only
// - Step reference open, on/off, short; capture each
// - Monitored classes: open, switch open/closed, short
// - Unmonitored: high is open, low closed
// - 120 V variant halves configured thresholds
// - Line monitoring only for monitored DC points
// - Background test drives two out-of-range levels
// - Line status one when healthy, not latched
// - Point one in LSB, sixteen in MSB
`ifndef LMIC_REGS_VH
`define LMIC_REGS_VH
`define LMIC_CTRL_ADDR      8'h00
`define LMIC_STATUS_ADDR    8'h04
`define LMIC_INPUT_ADDR     8'h08
`define LMIC_LINE_ADDR      8'h0C
`define LMIC_SUPP_ADDR      8'h10
`define LMIC_MON_ADDR       8'h14
`define LMIC_THR_OPEN_ADDR  8'h18
`define LMIC_THR_ONOFF_ADDR 8'h1C
`define LMIC_THR_SHORT_ADDR 8'h20
`define LMIC_THR_TON_ADDR   8'h24
`define LMIC_THR_TOFF_ADDR  8'h28
`define LMIC_TEST_ADDR      8'h2C
`define LMIC_IRQ_ST_ADDR    8'h30
`define LMIC_IRQ_MASK_ADDR  8'h34
`define LMIC_CTRL_SCAN_BIT  0
`define LMIC_CTRL_FAULT_BIT 1
`define LMIC_CTRL_TEST_BIT  2
`define LMIC_CTRL_HALF_BIT  3
`define LMIC_IRQ_SCAN_BIT   0
`define LMIC_IRQ_LINE_BIT   1
`define LMIC_IRQ_TEST_BIT   2
`define LMIC_THR_OPEN_RST   8'h14
`define LMIC_THR_ONOFF_RST  8'h0C
`define LMIC_THR_SHORT_RST  8'h04
`define LMIC_THR_TON_RST    8'h20
`define LMIC_THR_TOFF_RST   8'h00
`define LMIC_SETTLE_NS      2000
`define LMIC_CLK_NS         100
`define LMIC_SETTLE_CYC     ((`LMIC_SETTLE_NS + `LMIC_CLK_NS - 1) / `LMIC_CLK_NS)
`endif

// *** src/lmic_point_class.v ***
// Per-point classification and indicator decode
`timescale 1ns/1ns
module lmic_point_class (
  // Captured comparator results, one when input above reference
  input  wire abvOpen,
  input  wire abvOnOff,
  input  wire abvShort,
  // Point configuration
  input  wire monitored,
  input  wire suppress,
  // Results
  output wire isOn,
  output wire lineOk,
  output wire contactLed,
  output wire lineLed
);
  wire wireOpen;
  wire wireShort;
  assign wireOpen   = monitored & abvOpen;
  assign wireShort  = monitored & ~abvShort;
  assign isOn       = monitored ? (~abvOnOff & abvShort) : ~abvOnOff;
  assign lineOk     = monitored & ~wireOpen & ~wireShort;
  assign contactLed = isOn | wireShort;
  assign lineLed    = (wireOpen | wireShort) & ~suppress;
endmodule // lmic_point_class

// *** src/lmic_axil_slave.v ***
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/1ns
module lmic_axil_slave (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Write channels
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // Read channels
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Register file side
  output reg         wrStb,
  output reg  [7:0]  wrAddr,
  output reg  [31:0] wrData,
  output reg  [3:0]  wrStrb,
  output wire [7:0]  rdAddr,
  input  wire [31:0] rdValue,
  input  wire        rdOk
);
  reg       awHave;
  reg       wHave;
  reg [7:0] rdAddrReg;
  reg       rdPend;
  assign rdAddr = rdAddrReg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0; wready <= 1'b0; bvalid <= 1'b0; bresp <= 2'b00;
      awHave <= 1'b0; wHave <= 1'b0; wrStb <= 1'b0;
      wrAddr <= 8'h00; wrData <= 32'h0000_0000; wrStrb <= 4'h0;
    end else begin
      wrStb   <= 1'b0;
      awready <= ~awHave & ~awready & awvalid & ~bvalid;
      wready  <= ~wHave & ~wready & wvalid & ~bvalid;
      if (awready & awvalid) begin
        awHave <= 1'b1;
        wrAddr <= awaddr;
      end
      if (wready & wvalid) begin
        wHave  <= 1'b1;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (awHave & wHave & ~bvalid) begin
        wrStb  <= 1'b1;
        bvalid <= 1'b1;
        bresp  <= 2'b00;
        awHave <= 1'b0;
        wHave  <= 1'b0;
      end else if (bvalid & bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0; rvalid <= 1'b0; rdata <= 32'h0000_0000; rresp <= 2'b00;
      rdAddrReg <= 8'h00; rdPend <= 1'b0;
    end else begin
      arready <= ~rdPend & ~arready & ~rvalid & arvalid;
      if (arready & arvalid) begin
        rdAddrReg <= araddr;
        rdPend    <= 1'b1;
      end
      if (rdPend) begin
        rdPend <= 1'b0;
        rvalid <= 1'b1;
        rdata  <= rdOk ? rdValue : 32'h0000_0000;
        rresp  <= rdOk ? 2'b00 : 2'b10;
      end else if (rvalid & rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // lmic_axil_slave

// *** src/lmic_classifier.v ***
// Sixteen-point monitored input classifier with indicators and register file
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "lmic_regs.vh"
module lmic_classifier #(
  parameter NPTS = 16,
  parameter SETTLE = `LMIC_SETTLE_CYC
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // AXI4-Lite write
  input  wire [7:0]       awaddr,
  input  wire             awvalid,
  output wire             awready,
  input  wire [31:0]      wdata,
  input  wire [3:0]       wstrb,
  input  wire             wvalid,
  output wire             wready,
  output wire [1:0]       bresp,
  output wire             bvalid,
  input  wire             bready,
  // AXI4-Lite read
  input  wire [7:0]       araddr,
  input  wire             arvalid,
  output wire             arready,
  output wire [31:0]      rdata,
  output wire [1:0]       rresp,
  output wire             rvalid,
  input  wire             rready,
  // Reference converter and comparators
  output reg  [7:0]       refLevel,
  input  wire [NPTS-1:0]  cmpAbove,
  // Field power monitor pins
  input  wire             fieldVoltOk,
  input  wire             regulatorOk,
  // Front panel indicators
  output reg              ledHealth,
  output reg              ledFault,
  output reg              ledPower,
  output reg  [NPTS-1:0]  ledContact,
  output reg  [NPTS-1:0]  ledLine,
  // Interrupt
  output reg              irq
);
  localparam ST_IDLE  = 3'd0;
  localparam ST_OPEN  = 3'd1;
  localparam ST_ONOFF = 3'd2;
  localparam ST_SHORT = 3'd3;
  localparam ST_TON   = 3'd4;
  localparam ST_TOFF  = 3'd5;
  localparam ST_DONE  = 3'd6;

  // Synchronisers for pins
  reg [NPTS-1:0] cmpMeta;
  reg [NPTS-1:0] cmpSync;
  reg [1:0]      pwrMeta;
  reg [1:0]      pwrSync;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmpMeta <= {NPTS{1'b0}};
      cmpSync <= {NPTS{1'b0}};
      pwrMeta <= 2'b00;
      pwrSync <= 2'b00;
    end else begin
      cmpMeta <= cmpAbove;
      cmpSync <= cmpMeta;
      pwrMeta <= {fieldVoltOk, regulatorOk};
      pwrSync <= pwrMeta;
    end
  end

  // Register file
  reg [3:0]      ctrl_reg;
  reg [NPTS-1:0] supp_reg;
  reg [NPTS-1:0] mon_reg;
  reg [7:0]      thrOpen_reg;
  reg [7:0]      thrOnOff_reg;
  reg [7:0]      thrShort_reg;
  reg [7:0]      thrTon_reg;
  reg [7:0]      thrToff_reg;
  reg [2:0]      irqSt_reg;
  reg [2:0]      irqMask_reg;
  reg [NPTS-1:0] inputs_reg;
  reg [NPTS-1:0] lineOk_reg;
  reg [NPTS-1:0] testOn_reg;
  reg [NPTS-1:0] testOff_reg;

  wire        wrStb;
  wire [7:0]  wrAddr;
  wire [31:0] wrData;
  wire [3:0]  wrStrb;
  wire [7:0]  rdAddr;
  reg  [31:0] rdValue;
  reg         rdOk;

  lmic_axil_slave uBus (
    .clk     (clk),
    .rst_n   (rst_n),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wrStb   (wrStb),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .wrStrb  (wrStrb),
    .rdAddr  (rdAddr),
    .rdValue (rdValue),
    .rdOk    (rdOk)
  );

  wire wrLo;
  wire wrHi;
  assign wrLo = wrStb & wrStrb[0];
  assign wrHi = wrStb & wrStrb[1];

  // Sequencer
  reg  [2:0]      state_reg;
  reg  [7:0]      settle_reg;
  reg  [NPTS-1:0] capOpen_reg;
  reg  [NPTS-1:0] capOnOff_reg;
  reg  [NPTS-1:0] capTon_reg;
  reg             scanDone;
  reg             testDone;
  reg             lineChg;
  reg             testRun_reg;
  reg  [7:0]      thrSel;
  wire [NPTS-1:0] isOn;
  wire [NPTS-1:0] lineOk;
  wire [NPTS-1:0] contactLed;
  wire [NPTS-1:0] lineLed;
  wire            scanReq;
  wire            testReq;
  wire            settled;

  assign scanReq = wrLo && wrAddr == `LMIC_CTRL_ADDR && wrData[`LMIC_CTRL_SCAN_BIT];
  assign testReq = wrLo && wrAddr == `LMIC_CTRL_ADDR && wrData[`LMIC_CTRL_TEST_BIT];
  assign settled = settle_reg == 8'd0;

  always @* begin
    case (state_reg)
      ST_OPEN:  thrSel = thrOpen_reg;
      ST_ONOFF: thrSel = thrOnOff_reg;
      ST_SHORT: thrSel = thrShort_reg;
      ST_TON:   thrSel = thrTon_reg;
      ST_TOFF:  thrSel = thrToff_reg;
      default:  thrSel = thrOnOff_reg;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      settle_reg   <= 8'd0;
      refLevel     <= 8'h00;
      capOpen_reg  <= {NPTS{1'b0}};
      capOnOff_reg <= {NPTS{1'b0}};
      capTon_reg   <= {NPTS{1'b0}};
      inputs_reg   <= {NPTS{1'b0}};
      lineOk_reg   <= {NPTS{1'b0}};
      testOn_reg   <= {NPTS{1'b0}};
      testOff_reg  <= {NPTS{1'b0}};
      testRun_reg  <= 1'b0;
      scanDone     <= 1'b0;
      testDone     <= 1'b0;
      lineChg      <= 1'b0;
      ledContact   <= {NPTS{1'b0}};
      ledLine      <= {NPTS{1'b0}};
    end else begin
      scanDone <= 1'b0;
      testDone <= 1'b0;
      lineChg  <= 1'b0;
      if (state_reg != ST_IDLE && state_reg != ST_DONE) begin
        refLevel <= ctrl_reg[`LMIC_CTRL_HALF_BIT] ? {1'b0, thrSel[7:1]} : thrSel;
      end
      if (!settled) begin
        settle_reg <= settle_reg - 8'd1;
      end
      case (state_reg)
        ST_IDLE: begin
          if (scanReq || testReq) begin
            testRun_reg <= testReq;
            state_reg   <= testReq ? ST_TON : ST_OPEN;
            settle_reg  <= SETTLE[7:0];
          end
        end
        ST_OPEN: begin
          if (settled) begin
            capOpen_reg <= cmpSync;
            state_reg   <= ST_ONOFF;
            settle_reg  <= SETTLE[7:0];
          end
        end
        ST_ONOFF: begin
          if (settled) begin
            capOnOff_reg <= cmpSync;
            state_reg    <= ST_SHORT;
            settle_reg   <= SETTLE[7:0];
          end
        end
        ST_SHORT: begin
          if (settled) begin
            inputs_reg <= isOn;
            lineOk_reg <= lineOk;
            ledContact <= contactLed;
            ledLine    <= lineLed;
            scanDone   <= 1'b1;
            lineChg    <= lineOk != lineOk_reg;
            state_reg  <= ST_DONE;
          end
        end
        ST_TON: begin
          if (settled) begin
            capTon_reg <= cmpSync;
            state_reg  <= ST_TOFF;
            settle_reg <= SETTLE[7:0];
          end
        end
        ST_TOFF: begin
          if (settled) begin
            testOn_reg  <= ~capTon_reg;
            testOff_reg <= cmpSync;
            testDone    <= 1'b1;
            state_reg   <= ST_DONE;
          end
        end
        ST_DONE: begin
          testRun_reg <= 1'b0;
          state_reg   <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Per-point decode, short capture taken live in last step
  genvar gi;
  generate
    for (gi = 0; gi < NPTS; gi = gi + 1) begin : gPoint
      lmic_point_class uCls (
        .abvOpen    (capOpen_reg[gi]),
        .abvOnOff   (capOnOff_reg[gi]),
        .abvShort   (cmpSync[gi]),
        .monitored  (mon_reg[gi]),
        .suppress   (supp_reg[gi]),
        .isOn       (isOn[gi]),
        .lineOk     (lineOk[gi]),
        .contactLed (contactLed[gi]),
        .lineLed    (lineLed[gi])
      );
    end
  endgenerate

  // Configuration writes and sticky status
  wire [2:0] irqEvt;
  assign irqEvt = {testDone, lineChg, scanDone};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= 4'h0;
      supp_reg     <= {NPTS{1'b0}};
      mon_reg      <= {NPTS{1'b0}};
      thrOpen_reg  <= `LMIC_THR_OPEN_RST;
      thrOnOff_reg <= `LMIC_THR_ONOFF_RST;
      thrShort_reg <= `LMIC_THR_SHORT_RST;
      thrTon_reg   <= `LMIC_THR_TON_RST;
      thrToff_reg  <= `LMIC_THR_TOFF_RST;
      irqSt_reg    <= 3'b000;
      irqMask_reg  <= 3'b000;
    end else begin
      if (wrLo) begin
        case (wrAddr)
          `LMIC_CTRL_ADDR:      ctrl_reg <= {wrData[`LMIC_CTRL_HALF_BIT], 1'b0,
                                             wrData[`LMIC_CTRL_FAULT_BIT], 1'b0};
          `LMIC_SUPP_ADDR:      supp_reg[7:0] <= wrData[7:0];
          `LMIC_MON_ADDR:       mon_reg[7:0] <= wrData[7:0];
          `LMIC_THR_OPEN_ADDR:  thrOpen_reg <= wrData[7:0];
          `LMIC_THR_ONOFF_ADDR: thrOnOff_reg <= wrData[7:0];
          `LMIC_THR_SHORT_ADDR: thrShort_reg <= wrData[7:0];
          `LMIC_THR_TON_ADDR:   thrTon_reg <= wrData[7:0];
          `LMIC_THR_TOFF_ADDR:  thrToff_reg <= wrData[7:0];
          `LMIC_IRQ_MASK_ADDR:  irqMask_reg <= wrData[2:0];
          default: ;
        endcase
      end
      if (wrHi && wrAddr == `LMIC_SUPP_ADDR) begin
        supp_reg[NPTS-1:8] <= wrData[NPTS-1:8];
      end
      if (wrHi && wrAddr == `LMIC_MON_ADDR) begin
        mon_reg[NPTS-1:8] <= wrData[NPTS-1:8];
      end
      // Set wins over write-one-to-clear
      if (wrLo && wrAddr == `LMIC_IRQ_ST_ADDR) begin
        irqSt_reg <= (irqSt_reg & ~wrData[2:0]) | irqEvt;
      end else begin
        irqSt_reg <= irqSt_reg | irqEvt;
      end
    end
  end

  // Read mux
  always @* begin
    rdOk = 1'b1;
    case (rdAddr)
      `LMIC_CTRL_ADDR:      rdValue = {28'h000_0000, ctrl_reg[3], testRun_reg,
                                       ctrl_reg[1], state_reg != ST_IDLE};
      `LMIC_STATUS_ADDR:    rdValue = {29'h0000_0000, pwrSync, state_reg == ST_IDLE};
      `LMIC_INPUT_ADDR:     rdValue = {16'h0000, inputs_reg};
      `LMIC_LINE_ADDR:      rdValue = {16'h0000, lineOk_reg};
      `LMIC_SUPP_ADDR:      rdValue = {16'h0000, supp_reg};
      `LMIC_MON_ADDR:       rdValue = {16'h0000, mon_reg};
      `LMIC_THR_OPEN_ADDR:  rdValue = {24'h00_0000, thrOpen_reg};
      `LMIC_THR_ONOFF_ADDR: rdValue = {24'h00_0000, thrOnOff_reg};
      `LMIC_THR_SHORT_ADDR: rdValue = {24'h00_0000, thrShort_reg};
      `LMIC_THR_TON_ADDR:   rdValue = {24'h00_0000, thrTon_reg};
      `LMIC_THR_TOFF_ADDR:  rdValue = {24'h00_0000, thrToff_reg};
      `LMIC_TEST_ADDR:      rdValue = {testOff_reg, testOn_reg};
      `LMIC_IRQ_ST_ADDR:    rdValue = {29'h0000_0000, irqSt_reg};
      `LMIC_IRQ_MASK_ADDR:  rdValue = {29'h0000_0000, irqMask_reg};
      default: begin
        rdValue = 32'h0000_0000;
        rdOk    = 1'b0;
      end
    endcase
  end

  // Module indicators and interrupt
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ledHealth  <= 1'b0;
      ledFault   <= 1'b0;
      ledPower   <= 1'b0;
      irq        <= 1'b0;
    end else begin
      if (ctrl_reg[`LMIC_CTRL_FAULT_BIT]) begin
        ledFault  <= 1'b1;
        ledHealth <= 1'b0;
      end else begin
        ledFault <= 1'b0;
        if (scanReq) begin
          ledHealth <= ~ledHealth;
        end
      end
      ledPower <= pwrSync[1] & pwrSync[0];
      irq      <= |(irqSt_reg & irqMask_reg);
    end
  end
endmodule // lmic_classifier

// *** tb/lmic_classifier_asserts.sv ***
// Port timing checker for the classifier, bound to its top module
`timescale 1ns/1ns
module lmic_classifier_asserts #(
  parameter SETTLE = 20
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus handshakes
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Field side and indicators
  input wire logic [7:0]  refLevel,
  input wire logic        fieldVoltOk,
  input wire logic        regulatorOk,
  input wire logic        ledHealth,
  input wire logic        ledFault,
  input wire logic        ledPower
);
  logic [15:0] holdCnt;
  logic [7:0]  prevRef;
  // Cycles the reference has stood still
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdCnt <= 16'h0000;
      prevRef <= 8'h00;
    end else begin
      prevRef <= refLevel;
      holdCnt <= (refLevel != prevRef) ? 16'h0000 : holdCnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence arTaken;
    arvalid && arready;
  endsequence
  power_on_a: assert property ($past(rst_n, 3) && $past(fieldVoltOk && regulatorOk, 3) |-> ledPower)
    else $error("power indicator missing");
  power_off_a: assert property (!$past(fieldVoltOk && regulatorOk, 3) |-> !ledPower)
    else $error("power indicator without supply");
  fault_health_a: assert property (ledFault |-> !ledHealth)
    else $error("health lit during fault");
  ref_settle_a: assert property (refLevel != prevRef && prevRef != 0 |-> holdCnt >= SETTLE - 2)
    else $error("reference step too short");
  write_resp_a: assert property (wrTaken |-> ##[1:2] bvalid ##0 bresp == 2'b00)
    else $error("write response late or not okay");
  bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  read_resp_a: assert property (arTaken |-> ##[1:2] rvalid)
    else $error("read response late");
  rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped");
  rresp_code_a: assert property (rvalid |-> rresp == 2'b00 || rresp == 2'b10)
    else $error("bad read response code");
  ready_pulse_a: assert property ((awready |=> !awready) and (arready |=> !arready))
    else $error("ready held over one cycle");
endmodule // lmic_classifier_asserts

bind lmic_classifier lmic_classifier_asserts #(.SETTLE(SETTLE)) chkr (.clk, .rst_n, .awvalid,
  .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp,
  .rvalid, .rready, .refLevel, .fieldVoltOk, .regulatorOk, .ledHealth, .ledFault, .ledPower);

// *** tb/lmic_field_model.sv ***
// Field switches with optional line monitors seen through the comparators
`timescale 1ns/1ns
module lmic_field_model (
  // Reference and variant
  input  wire logic [7:0]   refLevel,
  input  wire logic         half,
  // Input volts per point, full scale
  input  wire logic [127:0] vin,
  // Comparator results
  output logic      [15:0]  cmpAbove
);
  // High voltage variant sees half of every level
  always_comb begin
    for (int p = 0; p < 16; p++) begin
      cmpAbove[p] = (half ? {1'b0, vin[p*8+1+:7]} : vin[p*8+:8]) > refLevel;
    end
  end
endmodule // lmic_field_model

// *** tb/lmic_classifier_bench.sv ***
// Register level bench for the classifier
`timescale 1ns/1ns
module lmic_classifier_bench;
  localparam logic [15:0] MON = 16'h00FF;
  localparam logic [15:0] SUPP = 16'hFF01;
  logic        clk = 0, rst_n = 0, half = 0, fieldVoltOk = 0, regulatorOk = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0, lastRef = 0;
  logic [31:0] wdata = 0, d;
  logic [3:0]  wstrb = 0;
  logic [1:0]  r;
  logic [127:0] vin = 0;
  logic [7:0]  refQ[$];
  wire         awready, wready, bvalid, arready, rvalid, ledHealth, ledFault, ledPower, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [7:0]  refLevel;
  wire  [15:0] cmpAbove, ledContact, ledLine;
  int          errorCnt = 0, checks = 0, i;
  always #50 clk = ~clk;
  lmic_classifier #(.SETTLE(4)) uut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .refLevel, .cmpAbove, .fieldVoltOk, .regulatorOk, .ledHealth, .ledFault,
    .ledPower, .ledContact, .ledLine, .irq);
  lmic_field_model field (.refLevel, .half, .vin, .cmpAbove);
  // Log of reference levels driven
  always @(posedge clk) begin
    if (refLevel !== lastRef) begin
      lastRef <= refLevel;
      if (refLevel != 0) refQ.push_back(refLevel);
    end
  end
  task summarize;
    $display("errors %0d checks %0d", errorCnt, checks);
    if (errorCnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task tmo;
    errorCnt++;
    $display("[FAIL] wait exp answer got none");
    summarize;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dv);
    int n;
    logic done;
    @(posedge clk);
    awaddr <= a; awvalid <= 1; wdata <= dv; wstrb <= 4'hF; wvalid <= 1; bready <= 1;
    done = 0;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        bready <= 0; done = 1;
      end
    end
    if (!done) tmo();
  endtask
  task rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rv);
    int n;
    logic done;
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    done = 0;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        dv = rdata; rv = rresp; rready <= 0; done = 1;
      end
    end
    if (!done) tmo();
  endtask
  task runOp(input logic [31:0] c);
    logic h;
    logic [15:0] lc;
    int n;
    h = !ledHealth; lc = ledContact; refQ.delete();
    wr(8'h00, c);
    repeat (2) @(posedge clk);
    if (c[0]) begin
      chk("health", h, ledHealth);
      chk("contact mid scan", lc, ledContact);
    end
    d = 0;
    for (n = 0; n < 100 && !d[0]; n++) rd(8'h04, d, r);
    if (!d[0]) tmo();
  endtask
  task checkPts;
    logic [15:0] eIn, eOk, eCon, eLin;
    logic [7:0] v;
    logic op, sh, cl;
    for (int p = 0; p < 16; p++) begin
      v = vin[p*8+:8];
      op = MON[p] && v > 20; sh = MON[p] && v < 4; cl = !op && !sh && v < 12;
      eOk[p] = MON[p] && !op && !sh; eCon[p] = cl || sh; eLin[p] = (op || sh) && !SUPP[p];
      eIn[p] = cl;
    end
    rd(8'h08, d, r);
    chk("inputs", eIn, d[15:0]);
    rd(8'h0C, d, r);
    chk("line ok", eOk, d);
    chk("contact led", eCon, ledContact);
    chk("line led", eLin, ledLine);
  endtask
  initial begin
    for (i = 0; i < 16; i++) vin[i*8+:8] = i < 8 ? 8'd24 - 8'd8 * (i % 4) : (i % 2 ? 0 : 24);
    repeat (12) @(posedge clk);
    rst_n <= 1;
    for (i = 0; i < 5; i++) begin
      rd(8'h18 + 4 * i, d, r);
      chk("threshold", {20, 12, 4, 32, 0} >> (32 * (4 - i)) & 32'hFF, d);
    end
    rd(8'h38, d, r);
    chk("unmapped resp", 2, r);
    chk("unmapped data", 0, d);
    for (i = 0; i < 4; i++) begin
      fieldVoltOk <= i[0]; regulatorOk <= i[1];
      repeat (5) @(posedge clk);
      chk("power", i == 3, ledPower);
    end
    wr(8'h14, MON);
    wr(8'h10, SUPP);
    runOp(32'h0000_0001);
    chk("steps", 32'h0014_0C04, {refQ[0], refQ[1], refQ[2]});
    checkPts;
    rd(8'h30, d, r);
    chk("irq events", 3, d);
    wr(8'h34, 0);
    repeat (3) @(posedge clk);
    chk("irq masked", 0, irq);
    wr(8'h34, 1);
    repeat (3) @(posedge clk);
    chk("irq raised", 1, irq);
    wr(8'h30, 7);
    rd(8'h30, d, r);
    chk("irq status", 0, d);
    chk("irq cleared", 0, irq);
    vin[31:24] <= 16; half <= 1;
    runOp(32'h0000_0009);
    chk("half steps", 32'h000A_0602, {refQ[0], refQ[1], refQ[2]});
    checkPts;
    vin <= {16{8'd24}}; half <= 0;
    runOp(32'h0000_0004);
    chk("test level", 32, refQ[0]);
    rd(8'h2C, d, r);
    chk("test result", 32'hFFFF_FFFF, d);
    wr(8'h00, 2);
    repeat (2) @(posedge clk);
    chk("fault led", 1, ledFault);
    chk("health off", 0, ledHealth);
    wr(8'h00, 0);
    repeat (2) @(posedge clk);
    chk("fault clear", 0, ledFault);
    summarize;
  end
endmodule // lmic_classifier_bench
